// [design/cs_spindle_servo.sv]
// clv spindle servo top: apb registers, mode control, spindle pins
`timescale 1ns/10ps
`default_nettype none
module cs_spindle_servo
  import cs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_frame_ref,
  input wire logic vco_frame_ref,
  input wire logic vco_tick,
  input wire logic vco_half_tick,
  input wire logic seek_ref_tick,
  input wire logic efm_in,
  input wire logic playback_frame,
  input wire logic frame_lock,
  input wire logic read_base_tick,
  input wire logic write_base_tick,
  output logic spindle_drive_out,
  output logic spindle_drive_oe,
  output logic spindle_phase_out,
  output logic spindle_phase_oe,
  output logic spindle_filter_out,
  output logic spindle_on_out,
  output logic status_out_n
);
  // register decode, used by the error answer
  function automatic logic cs_mapped(input logic [7:0] a);
    return a == CS_CFG_OFF || a == CS_CMD_OFF || a == CS_WST_OFF ||
           a == CS_PHC_OFF || a == CS_SEEK_OFF || a == CS_STAT_OFF;
  endfunction
  // speed width comparison: returns {oe, level}
  function automatic logic [1:0] cs_width_drive(input logic [7:0] w);
    if (w <= CS_W_LOW) begin
      return 2'b10;
    end else if (w == CS_W_MID) begin
      return 2'b00;
    end
    return 2'b11;
  endfunction

  logic [2:0] cfg_q;
  cs_cmd_t cmd_q;
  logic wst_q;
  logic phc_q;
  logic seek_q;
  logic armed_q;
  logic stat_en_q;
  cs_state_t state_q;
  cs_state_t state_d;
  logic wr_en;
  logic [7:0] width;
  logic ref_tick;
  logic peak_div_tick;
  logic peak_tick;
  logic bot_tick;
  logic sample_tick;
  logic bot_sel;
  logic pb_q;
  logic pb_fall;
  logic pb_rise;
  logic [1:0] div_a_q;
  logic [1:0] div_b_q;
  logic [9:0] wp_q;
  logic [14:0] ph_cnt_q;
  logic [3:0] low_cnt_q;
  logic [1:0] duty_q;
  logic [1:0] wdrv;

  assign wr_en = psel && penable && pwrite && pready;
  assign pb_fall = pb_q && !playback_frame;
  assign pb_rise = !pb_q && playback_frame;
  // rough mode swaps the crystal reference for the vco one
  assign ref_tick = (cmd_q == CS_CMD_ROUGH) ? vco_frame_ref :
                    crystal_frame_ref;
  assign peak_tick = (state_q == CS_ST_SEEK) ? seek_ref_tick :
                     peak_div_tick;
  assign bot_sel = (state_q == CS_ST_SEEK) ? seek_q :
                   cfg_q[CS_CFG_BOT_BIT];
  assign wdrv = cs_width_drive(width);

  // host register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CS_CFG_RST;
      cmd_q <= cs_cmd_t'(CS_CMD_RST);
      wst_q <= 1'b0;
      phc_q <= 1'b0;
      seek_q <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        CS_CFG_OFF: cfg_q <= pwdata[2:0];
        CS_CMD_OFF: cmd_q <= cs_cmd_t'(pwdata[2:0]);
        CS_WST_OFF: wst_q <= pwdata[CS_WST_EN_BIT];
        CS_PHC_OFF: phc_q <= pwdata[CS_PHC_SRC_BIT];
        CS_SEEK_OFF: seek_q <= pwdata[CS_SEEK_BOT_BIT];
        default: ;
      endcase
    end
  end

  // status pin arming: only a width config write that precedes the
  // next command write, whatever its code, enables the pulse width report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
      stat_en_q <= 1'b0;
    end else if (wr_en && paddr == CS_WST_OFF) begin
      armed_q <= pwdata[CS_WST_EN_BIT];
    end else if (wr_en && paddr == CS_CMD_OFF) begin
      stat_en_q <= armed_q;
      armed_q <= 1'b0;
    end
  end

  // apb answer: zero wait, read data and error prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= !cs_mapped(paddr);
        prdata <= 32'h0;
        unique case (paddr)
          CS_CFG_OFF: prdata <= {29'h0, cfg_q};
          CS_CMD_OFF: prdata <= {29'h0, cmd_q};
          CS_WST_OFF: prdata <= {31'h0, wst_q};
          CS_PHC_OFF: prdata <= {31'h0, phc_q};
          CS_SEEK_OFF: prdata <= {31'h0, seek_q};
          CS_STAT_OFF: prdata <= {14'h0, low_cnt_q, state_q, width};
          default: ;
        endcase
      end
    end
  end

  // hold clocks: peak /2 or /4, bottom /16 or /32 of the reference
  cs_tick_div u_peak_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(ref_tick),
    .ratio(cfg_q[CS_CFG_PEAK_BIT] ? CS_PEAK_DIV_HI : CS_PEAK_DIV_LO),
    .tick_out(peak_div_tick)
  );
  cs_tick_div u_bot_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(ref_tick),
    .ratio(bot_sel ? CS_BOT_DIV_HI : CS_BOT_DIV_LO),
    .tick_out(bot_tick)
  );
  // lock sampling every sixteenth playback frame
  cs_tick_div u_sample_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(pb_fall),
    .ratio(CS_SAMPLE_DIV),
    .tick_out(sample_tick)
  );
  cs_width_meter u_width (
    .pclk(pclk),
    .presetn(presetn),
    .t_tick(vco_tick),
    .efm_in(efm_in),
    .peak_tick(peak_tick),
    .bottom_tick(bot_tick),
    .width_q(width)
  );

  // consecutive low lock samples, saturating at the loss count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= 4'h0;
    end else if (sample_tick) begin
      if (frame_lock) begin
        low_cnt_q <= 4'h0;
      end else if (low_cnt_q != CS_LOCK_LOST_N) begin
        low_cnt_q <= low_cnt_q + 4'h1;
      end
    end
  end

  // mode selection: exactly one state from the written command
  always_comb begin
    state_d = CS_ST_STOP;
    unique case (cmd_q)
      CS_CMD_STOP: state_d = CS_ST_STOP;
      CS_CMD_FWD: state_d = CS_ST_FWD;
      CS_CMD_REV: state_d = CS_ST_REV;
      CS_CMD_SPEED: state_d = CS_ST_SPEED;
      CS_CMD_SEEK: state_d = CS_ST_SEEK;
      CS_CMD_PHASE: state_d = CS_ST_PHASE;
      CS_CMD_AUTO, CS_CMD_ROUGH: begin
        state_d = (low_cnt_q == CS_LOCK_LOST_N) ? CS_ST_SPEED :
                  CS_ST_PHASE;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CS_ST_STOP;
    end else begin
      state_q <= state_d;
    end
  end

  // phase sources divided by four; counters run in every mode so a
  // switch into phase mode starts from a settled comparison
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_q <= 1'b0;
      div_a_q <= 2'h0;
      div_b_q <= 2'h0;
    end else begin
      pb_q <= playback_frame;
      if (phc_q ? read_base_tick : pb_rise) begin
        div_a_q <= div_a_q + 2'h1;
      end
      if (phc_q ? write_base_tick : ref_tick) begin
        div_b_q <= div_b_q + 2'h1;
      end
    end
  end

  // playback frame high time in vco/2 periods and phase pin timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 10'h0;
      ph_cnt_q <= 15'h0;
    end else begin
      if (pb_rise) begin
        wp_q <= {9'h000, vco_half_tick}; // rise cycle is high already
      end else if (playback_frame && vco_half_tick && wp_q != 10'h3ff) begin
        wp_q <= wp_q + 10'h1;
      end
      if (pb_fall) begin
        ph_cnt_q <= (wp_q > CS_WP_OFFSET) ?
          ({5'h00, wp_q - CS_WP_OFFSET} << CS_WP_SHIFT) : 15'h0;
      end else if (vco_half_tick && ph_cnt_q != 15'h0) begin
        ph_cnt_q <= ph_cnt_q - 15'h1;
      end
    end
  end

  // duty divider: low gain lets the drive through one cycle in four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_q <= 2'h0;
    end else begin
      duty_q <= duty_q + 2'h1;
    end
  end

  // spindle pin patterns per state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spindle_drive_out <= 1'b0;
      spindle_drive_oe <= 1'b1;
      spindle_phase_out <= 1'b0;
      spindle_phase_oe <= 1'b0;
      spindle_filter_out <= 1'b0;
      spindle_on_out <= 1'b0;
    end else begin
      spindle_filter_out <= 1'b0;
      spindle_phase_out <= 1'b0;
      spindle_phase_oe <= 1'b0;
      spindle_on_out <= 1'b1;
      unique case (state_q)
        CS_ST_STOP: begin
          spindle_drive_out <= 1'b0;
          spindle_drive_oe <= 1'b1;
          spindle_on_out <= 1'b0;
        end
        CS_ST_FWD: begin
          spindle_drive_out <= 1'b1;
          spindle_drive_oe <= 1'b1;
        end
        CS_ST_REV: begin
          spindle_drive_out <= 1'b0;
          spindle_drive_oe <= 1'b1;
        end
        CS_ST_SPEED, CS_ST_SEEK: begin
          spindle_drive_out <= wdrv[0];
          spindle_drive_oe <= wdrv[1] &&
            (cfg_q[CS_CFG_GAIN_BIT] || duty_q == 2'h0);
        end
        CS_ST_PHASE: begin
          // b leading means the disc is slow: push, else brake
          spindle_drive_out <= div_b_q[1];
          spindle_drive_oe <= div_a_q[1] != div_b_q[1];
          spindle_phase_out <= ph_cnt_q != 15'h0;
          spindle_phase_oe <= 1'b1;
        end
        default: begin
          spindle_drive_out <= 1'b0;
          spindle_drive_oe <= 1'b1;
          spindle_on_out <= 1'b0;
        end
      endcase
    end
  end

  // active-low pulse width report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_out_n <= 1'b1;
    end else begin
      status_out_n <= !(stat_en_q && width >= CS_W_STAT);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lock_lost;
    cmd_q == CS_CMD_AUTO && low_cnt_q == CS_LOCK_LOST_N;
  endsequence
  property p_fwd;
    state_q == CS_ST_FWD |=> spindle_drive_oe && spindle_drive_out &&
      !spindle_phase_oe && !spindle_filter_out && spindle_on_out;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward pins wrong");
  property p_rev;
    state_q == CS_ST_REV |=> spindle_drive_oe && !spindle_drive_out &&
      !spindle_phase_oe && spindle_on_out;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse pins wrong");
  property p_stop;
    state_q == CS_ST_STOP |=> !spindle_drive_out && !spindle_on_out &&
      !spindle_filter_out && !spindle_phase_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop pins wrong");
  property p_speed_low;
    state_q == CS_ST_SPEED && cfg_q[CS_CFG_GAIN_BIT] && width <= CS_W_LOW
      |=> spindle_drive_oe && !spindle_drive_out;
  endproperty
  a_speed_low: assert property (p_speed_low)
    else $error("short width not driven low");
  property p_speed_mid;
    state_q == CS_ST_SPEED && width == CS_W_MID |=> !spindle_drive_oe;
  endproperty
  a_speed_mid: assert property (p_speed_mid)
    else $error("nominal width not hi-z");
  property p_gain;
    state_q == CS_ST_SPEED && !cfg_q[CS_CFG_GAIN_BIT] && duty_q != 2'h0
      |=> !spindle_drive_oe;
  endproperty
  a_gain: assert property (p_gain) else $error("gain cut missing");
  property p_auto;
    s_lock_lost |=> state_q == CS_ST_SPEED;
  endproperty
  a_auto: assert property (p_auto) else $error("no speed on loss");
  property p_phase_len;
    pb_fall && wp_q > CS_WP_OFFSET |=>
      ph_cnt_q == ({5'h00, $past(wp_q) - CS_WP_OFFSET} << CS_WP_SHIFT);
  endproperty
  a_phase_len: assert property (p_phase_len)
    else $error("phase pin length wrong");
  property p_cmd;
    wr_en && paddr == CS_CMD_OFF && pwdata[2:0] == CS_CMD_FWD
      |=> ##1 state_q == CS_ST_FWD;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command ignored");
endmodule // cs_spindle_servo
`default_nettype wire

// [design/cs_pkg.sv]
// constants, codes and register map of the clv spindle servo
// Functional notes
// - five host registers carry mode and parameters
// - forward: drive high, phase hi-z, on high
// - reverse: drive low, phase hi-z, on high
// - stop: drive low, filter and on low
// - speed mode when jumping or unlocked
// - width peak/bottom hold at selected rates
// - speed drive low/hi-z/high by width 21/22/23
// - gain low cuts speed drive twelve dB
// - seek uses seek clock peak, frame bottom
// - phase mode compares selected sources by four
// - phase pin high (count-278)x32 after fall
// - auto mode: eight low lock samples go speed
// - rough mode takes reference from the vco
package cs_pkg;
  // register byte offsets
  localparam logic [7:0] CS_CFG_OFF = 8'h00;
  localparam logic [7:0] CS_CMD_OFF = 8'h04;
  localparam logic [7:0] CS_WST_OFF = 8'h08;
  localparam logic [7:0] CS_PHC_OFF = 8'h0c;
  localparam logic [7:0] CS_SEEK_OFF = 8'h10;
  localparam logic [7:0] CS_STAT_OFF = 8'h14;
  // field positions
  localparam int CS_CFG_GAIN_BIT = 0;
  localparam int CS_CFG_PEAK_BIT = 1;
  localparam int CS_CFG_BOT_BIT = 2;
  localparam int CS_SEEK_BOT_BIT = 0;
  localparam int CS_WST_EN_BIT = 0;
  localparam int CS_PHC_SRC_BIT = 0;
  // reset values
  localparam logic [2:0] CS_CFG_RST = 3'h0;
  localparam logic [2:0] CS_CMD_RST = 3'h0;
  // divider ratios
  localparam logic [5:0] CS_PEAK_DIV_LO = 6'h02;
  localparam logic [5:0] CS_PEAK_DIV_HI = 6'h04;
  localparam logic [5:0] CS_BOT_DIV_LO = 6'h10;
  localparam logic [5:0] CS_BOT_DIV_HI = 6'h20;
  localparam logic [5:0] CS_SAMPLE_DIV = 6'h10;
  // width thresholds in vco periods
  localparam logic [7:0] CS_W_LOW = 8'h15;
  localparam logic [7:0] CS_W_MID = 8'h16;
  localparam logic [7:0] CS_W_STAT = 8'h40;
  // phase pin timing
  localparam logic [9:0] CS_WP_OFFSET = 10'h116;
  localparam int CS_WP_SHIFT = 5;
  // lock loss sample count
  localparam logic [3:0] CS_LOCK_LOST_N = 4'h8;
  // command codes
  typedef enum logic [2:0] {
    CS_CMD_STOP = 3'h0,
    CS_CMD_FWD = 3'h1,
    CS_CMD_REV = 3'h2,
    CS_CMD_SPEED = 3'h3,
    CS_CMD_SEEK = 3'h4,
    CS_CMD_PHASE = 3'h5,
    CS_CMD_AUTO = 3'h6,
    CS_CMD_ROUGH = 3'h7
  } cs_cmd_t;
  // one-hot servo states
  typedef enum logic [5:0] {
    CS_ST_STOP = 6'h01,
    CS_ST_FWD = 6'h02,
    CS_ST_REV = 6'h04,
    CS_ST_SPEED = 6'h08,
    CS_ST_SEEK = 6'h10,
    CS_ST_PHASE = 6'h20
  } cs_state_t;
endpackage

// [design/cs_tick_div.sv]
// enable pulse divider: one pulse out per ratio pulses in
`timescale 1ns/10ps
`default_nettype none
module cs_tick_div
  import cs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic [5:0] ratio,
  output logic tick_out
);
  logic [5:0] cnt_q;
  // counter wraps at ratio-1, a ratio change takes effect at the next input pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_q >= ratio - 6'h01) begin
          cnt_q <= 6'h00;
          tick_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end
endmodule // cs_tick_div
`default_nettype wire

// [design/cs_width_meter.sv]
// longest efm run length with peak hold and bottom hold
`timescale 1ns/10ps
`default_nettype none
module cs_width_meter
  import cs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic t_tick,
  input wire logic efm_in,
  input wire logic peak_tick,
  input wire logic bottom_tick,
  output logic [7:0] width_q
);
  logic efm_q;
  logic [7:0] run_q;
  logic [7:0] peak_q;
  logic [7:0] bot_q;
  // run length in vco periods, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      efm_q <= 1'b0;
      run_q <= 8'h00;
    end else begin
      efm_q <= efm_in;
      if (efm_q != efm_in) begin
        run_q <= {7'h00, t_tick}; // the change cycle is the first period
      end else if (t_tick && run_q != 8'hff) begin
        run_q <= run_q + 8'h01;
      end
    end
  end
  // peak hold keeps the longest run; bottom hold keeps the least peak,
  // which strips long noise runs such as mirror regions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_q <= 8'h00;
      bot_q <= 8'hff;
      width_q <= 8'h00;
    end else begin
      if (peak_tick) begin
        peak_q <= 8'h00;
        if (peak_q < bot_q) begin
          bot_q <= peak_q;
        end
      end else if (run_q > peak_q) begin
        peak_q <= run_q;
      end
      if (bottom_tick) begin
        // a peak window closing on the same tick still takes part
        width_q <= (peak_tick && peak_q < bot_q) ? peak_q : bot_q;
        bot_q <= 8'hff;
      end
    end
  end
endmodule // cs_width_meter
`default_nettype wire

// [sim/cs_motor_model.sv]
// motor driver model on the far side of the spindle pins
`timescale 1ns/10ps
`default_nettype none
module cs_motor_model
  import cs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drive_out,
  input wire logic drive_oe,
  input wire logic phase_out,
  input wire logic phase_oe,
  input wire logic on_in,
  output logic drive_wire,
  output logic phase_wire,
  output logic [1:0] spin
);
  // a released line floats: show a toggling pattern, never a stale level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_wire <= 1'b0;
      phase_wire <= 1'b0;
    end else begin
      drive_wire <= drive_oe ? drive_out : ~drive_wire;
      phase_wire <= phase_oe ? phase_out : ~phase_wire;
    end
  end
  // 1 forward, 2 reverse, 0 stopped
  always_comb spin = !on_in ? 2'h0 :
    (drive_wire ? 2'h1 : 2'h2);
endmodule // cs_motor_model
`default_nettype wire

// [sim/tb_clv_spindle_servo.sv]
// self-checking bench of the clv spindle servo
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t mismatch %h vs %h", $time, (a), (b)); end end
module tb_clv_spindle_servo
  import cs_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, efm_in = 0, playback_frame = 0;
  logic crystal_frame_ref = 0, vco_frame_ref = 0, seek_ref_tick = 0;
  logic read_base_tick = 0, write_base_tick = 0, frame_lock = 0;
  logic drv, drv_oe, ph, ph_oe, filt, on, stat_n, drive_wire, phase_wire;
  logic [1:0] spin, ex;
  logic vco_on = 1'b1;
  int errors = 0, num_checks = 0, cyc = 0, run_len = 20, run_cnt = 0;
  int pf_cnt = 0, hi_len = 20, lo_len = 20, cnt, i, k;
  logic [31:0] seed = 32'h00015d63;
  always #20 pclk = ~pclk;
  cs_spindle_servo uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_frame_ref(crystal_frame_ref), .vco_frame_ref(vco_frame_ref),
    .vco_tick(1'b1), .vco_half_tick(1'b1), .seek_ref_tick(seek_ref_tick),
    .efm_in(efm_in), .playback_frame(playback_frame),
    .frame_lock(frame_lock), .read_base_tick(read_base_tick),
    .write_base_tick(write_base_tick), .spindle_drive_out(drv),
    .spindle_drive_oe(drv_oe), .spindle_phase_out(ph),
    .spindle_phase_oe(ph_oe), .spindle_filter_out(filt),
    .spindle_on_out(on), .status_out_n(stat_n));
  cs_motor_model mot (.pclk(pclk), .presetn(presetn), .drive_out(drv),
    .drive_oe(drv_oe), .phase_out(ph), .phase_oe(ph_oe), .on_in(on),
    .drive_wire(drive_wire), .phase_wire(phase_wire), .spin(spin));
  // frame references, base ticks, efm runs and playback frames
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    crystal_frame_ref <= (cyc % 64 == 0);
    vco_frame_ref <= vco_on && (cyc % 64 == 32);
    seek_ref_tick <= (cyc % 128 == 5);
    read_base_tick <= (cyc % 7 == 0);
    write_base_tick <= (cyc % 9 == 0);
    run_cnt <= (run_cnt >= run_len - 1) ? 0 : run_cnt + 1;
    if (run_cnt >= run_len - 1) efm_in <= ~efm_in;
    pf_cnt <= (pf_cnt >= (playback_frame ? hi_len : lo_len) - 1) ? 0
      : pf_cnt + 1;
    if (pf_cnt >= (playback_frame ? hi_len : lo_len) - 1)
      playback_frame <= ~playback_frame;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected {enable, level} of the drive pin for runs of w periods
  function automatic logic [1:0] exp_drive(input int w);
    if (w <= CS_W_LOW) return 2'b10;
    if (w == CS_W_MID) return 2'b00;
    return 2'b11;
  endfunction
  // one apb transfer; only the watchdog ends the wait for pready
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pins(input logic d, input logic de, input logic o);
    if (de) `CHK(drv, d)
    `CHK(drv_oe, de)
    `CHK(ph_oe, 1'b0)
    `CHK(filt, 1'b0)
    `CHK(on, o)
  endtask
  task automatic settle(input int n);
    run_len = n;
    repeat (3500) @(posedge pclk);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard sized well above the planned run of about 48k cycles
  initial begin
    #3000000;
    errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    pins(1'b0, 1'b1, 1'b0);
    `CHK(stat_n, 1'b1)
    `CHK(pready, 1'b0)
    apb(0, CS_CFG_OFF, 0);
    `CHK(rdata[2:0], CS_CFG_RST)
    `CHK(pready, 1'b1)
    apb(0, CS_CMD_OFF, 0);
    `CHK(rdata[2:0], CS_CMD_RST)
    for (i = 0; i < 4; i++) begin
      k = rnd();
      apb(1, CS_CFG_OFF, k);
      apb(1, CS_PHC_OFF, k >> 3);
      apb(0, CS_CFG_OFF, 0);
      `CHK(rdata, {29'h0, k[2:0]})
      apb(0, CS_PHC_OFF, 0);
      `CHK(rdata, {31'h0, k[3]})
    end
    apb(0, 8'h18, 0);
    `CHK({rerr, rdata}, 33'h100000000)
    apb(1, CS_STAT_OFF, 32'hffffffff);
    `CHK(rerr, 1'b0)
    // mode patterns appear two cycles after the write edge
    apb(1, CS_CMD_OFF, CS_CMD_FWD);
    repeat (2) @(posedge pclk);
    #1;
    pins(1'b1, 1'b1, 1'b1);
    @(posedge pclk);
    #1;
    `CHK(spin, 2'h1)
    apb(1, CS_CMD_OFF, CS_CMD_REV);
    repeat (2) @(posedge pclk);
    #1;
    pins(1'b0, 1'b1, 1'b1);
    apb(1, CS_CMD_OFF, CS_CMD_STOP);
    repeat (2) @(posedge pclk);
    #1;
    pins(1'b0, 1'b1, 1'b0);
    // long widths, width report first unarmed, then armed in order
    apb(1, CS_CFG_OFF, 1);
    apb(1, CS_WST_OFF, 0);
    apb(1, CS_CMD_OFF, CS_CMD_SPEED);
    settle(70);
    `CHK(stat_n, 1'b1)
    pins(1'b1, 1'b1, 1'b1);
    apb(1, CS_WST_OFF, 1);
    apb(1, CS_CMD_OFF, CS_CMD_SPEED);
    repeat (20) @(posedge pclk);
    #1;
    `CHK(stat_n, 1'b0)
    // corner widths 20, 22 and 25, then one random width
    for (i = 0; i < 4; i++) begin
      k = (i == 3) ? 17 + rnd() % 12 : 20 + 2 * i + (i == 2);
      settle(k);
      ex = exp_drive(k);
      pins(ex[0], ex[1], 1'b1);
    end
    // low gain keeps the drive up one cycle in four
    for (i = 0; i < 2; i++) begin
      apb(1, CS_CFG_OFF, i);
      settle(25);
      cnt = 0;
      repeat (16) begin
        @(posedge pclk);
        #1;
        if (drv_oe === 1'b1 && drv === 1'b1) cnt++;
      end
      `CHK(cnt, i ? 16 : 4)
    end
    apb(1, CS_SEEK_OFF, rnd());
    apb(1, CS_CMD_OFF, CS_CMD_SEEK);
    settle(25);
    pins(1'b1, 1'b1, 1'b1);
    // phase pin width from the random high playback period
    k = 1 + rnd() % 4;
    hi_len = 278 + k;
    lo_len = 200;
    apb(1, CS_CMD_OFF, CS_CMD_PHASE);
    @(negedge playback_frame);
    @(negedge playback_frame);
    cnt = 0;
    repeat (190) begin
      @(posedge pclk);
      #1;
      if (ph_oe === 1'b1 && ph === 1'b1) cnt++;
    end
    `CHK(cnt, k * 32)
    `CHK(phase_wire, 1'b0)
    // lock sampling in auto and vco rough mode
    hi_len = 20;
    lo_len = 20;
    for (i = 0; i < 2; i++) begin
      frame_lock <= 1'b0;
      apb(1, CS_CMD_OFF, i ? CS_CMD_ROUGH : CS_CMD_AUTO);
      repeat (6000) @(posedge pclk);
      apb(0, CS_STAT_OFF, 0);
      `CHK(rdata[13:8], CS_ST_SPEED)
      frame_lock <= 1'b1;
      repeat (1400) @(posedge pclk);
      apb(0, CS_STAT_OFF, 0);
      `CHK(rdata[13:8], CS_ST_PHASE)
      apb(1, CS_CMD_OFF, CS_CMD_STOP);
    end
    // a frozen vco reference freezes the width in rough mode,
    // although the crystal reference goes on and the runs shrink
    apb(1, CS_CMD_OFF, CS_CMD_ROUGH);
    vco_on <= 1'b0;
    settle(20);
    apb(0, CS_STAT_OFF, 0);
    `CHK(rdata[7:0], 8'h19)
    conclude();
  end
endmodule // tb_clv_spindle_servo
`default_nettype wire
